/* src/acsc_top.sv */
/*
 * Receive cell status byte, clear-on-read cell counters and an interrupt
 * status/mask pair for an ATM transmission-convergence block.
 * Assumes events come from logic on mclk_i and a master that never waits.
 */
`timescale 1ns/1ps
`include "acsc_params.svh"

// How it works
// - Reading the receive status byte clears its event bits.
// - Status bit 7 shows delineation loss live, high while lost.
// - Event bits latch on occurrence and hold until the next read.
// - Bit 6 sets on an uncorrectable header error.
// - Bit 5 sets on a corrected header error.
// - Bit 3 sets when a valid cell is received.
// - Bit 2 sets when a masked header matches the idle value.
// - Bit 1 sets when screening rejects a cell.
// - Bit 0 sets when a header carries a nonzero GFC.
// - Idle cells count in 19 bits over three bytes; top five bits read 0.
// - Idle counter bytes clear on read; low byte read first.
// - Eight-bit counter counts delineation losses, not recoveries.
// - Delineation interrupt event fires on both loss and recovery.
// - Sent cells count in 19 bits over three clear-on-read bytes.
// - Corrected header errors count in an 8-bit clear-on-read counter.
module acsc_top #(
    parameter int CW = 19  // Width of the idle and sent cell counters
) (
    input  wire logic              mclk_i,   // 25 MHz clock
    input  wire logic              rst_b_i,  // Async reset, active low
    input  wire logic [7:0]        addr_i,   // Register address
    input  wire logic [7:0]        wdata_i,  // Write data
    input  wire logic              wr_i,     // Write strobe
    input  wire logic              rd_i,     // Read strobe
    input  wire acsc_pkg::acsc_evt_s evt_i,  // Cell events, same clock
    output logic [7:0]             rdata_o,  // Read data, cycle after read
    output logic                   irq_o     // Level interrupt
);

    localparam int HW = CW - 16;  // Bits held in the high byte

    logic                  rst_s1_ff;
    logic                  rst_sync_b;
    logic [7:0]            rx_ev_ff;
    logic [7:0]            nxt_rx_ev;
    logic                  loss_q_ff;
    logic                  loss_rise;
    logic                  loss_change;
    logic [CW-1:0]         idle_cnt;
    logic [CW-1:0]         sent_cnt;
    logic [7:0]            loss_cnt;
    logic [7:0]            corr_cnt;
    logic [7:0]            idle_mid_ff;
    logic [HW-1:0]         idle_high_ff;
    logic [7:0]            sent_mid_ff;
    logic [HW-1:0]         sent_high_ff;
    logic [7:0]            int_st_ff;
    logic [7:0]            int_mask_ff;
    logic [7:0]            int_ev;
    logic [7:0]            rd_mux;

    // Read strobe aimed at one offset
    function automatic logic rd_at(input logic [7:0] ofs);
        rd_at = rd_i && (addr_i == ofs);
    endfunction : rd_at

    // Write strobe aimed at one offset
    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = wr_i && (addr_i == ofs);
    endfunction : wr_at

    // Reset release through two flip-flops
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_ff  <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_s1_ff  <= 1'b1;
            rst_sync_b <= rst_s1_ff;
        end
    end

    // Delineation edges: rise counts, either edge raises an interrupt event
    always_ff @(posedge mclk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            loss_q_ff <= 1'b0;
        end else begin
            loss_q_ff <= evt_i.delineation_lost;
        end
    end
    assign loss_rise   = evt_i.delineation_lost && !loss_q_ff;
    assign loss_change = evt_i.delineation_lost ^ loss_q_ff;

    // Sticky receive events; a new event wins over the clearing read
    always_comb begin
        nxt_rx_ev = rd_at(`ACSC_OFS_RX_STATUS) ? 8'h00 : rx_ev_ff;
        nxt_rx_ev[`ACSC_BIT_UNCORR] = nxt_rx_ev[`ACSC_BIT_UNCORR]
                                    | evt_i.hec_uncorrected_seen;
        nxt_rx_ev[`ACSC_BIT_CORR]   = nxt_rx_ev[`ACSC_BIT_CORR]
                                    | evt_i.hec_corrected_seen;
        nxt_rx_ev[`ACSC_BIT_VALID]  = nxt_rx_ev[`ACSC_BIT_VALID]
                                    | evt_i.valid_cell_seen;
        nxt_rx_ev[`ACSC_BIT_IDLE]   = nxt_rx_ev[`ACSC_BIT_IDLE]
                                    | evt_i.idle_cell_seen;
        nxt_rx_ev[`ACSC_BIT_SCREEN] = nxt_rx_ev[`ACSC_BIT_SCREEN]
                                    | evt_i.screened_out_cell;
        nxt_rx_ev[`ACSC_BIT_GFC]    = nxt_rx_ev[`ACSC_BIT_GFC]
                                    | evt_i.gfc_nonzero_seen;
        nxt_rx_ev[`ACSC_BIT_LOSS]   = 1'b0;  // Live bit, not stored
        nxt_rx_ev[`ACSC_BIT_RSVD]   = 1'b0;  // Reserved, reads 0
    end

    // Receive event register
    always_ff @(posedge mclk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rx_ev_ff <= `ACSC_RST_BYTE;
        end else begin
            rx_ev_ff <= nxt_rx_ev;
        end
    end

    // Idle cell counter, cleared whole by a low byte read
    acsc_counter #(.W(CW)) u_idle_cnt (
        .clk_i   (mclk_i),
        .rst_b_i (rst_sync_b),
        .inc_i   (evt_i.idle_cell_seen),
        .clr_i   (rd_at(`ACSC_OFS_IDLE_LOW)),
        .cnt_o   (idle_cnt)
    );

    // Sent cell counter, cleared whole by a low byte read
    acsc_counter #(.W(CW)) u_sent_cnt (
        .clk_i   (mclk_i),
        .rst_b_i (rst_sync_b),
        .inc_i   (evt_i.sent_cell),
        .clr_i   (rd_at(`ACSC_OFS_TX_LOW)),
        .cnt_o   (sent_cnt)
    );

    // Delineation loss counter, read only, never cleared
    acsc_counter #(.W(8)) u_loss_cnt (
        .clk_i   (mclk_i),
        .rst_b_i (rst_sync_b),
        .inc_i   (loss_rise),
        .clr_i   (1'b0),
        .cnt_o   (loss_cnt)
    );

    // Corrected header error counter, clear on read
    acsc_counter #(.W(8)) u_corr_cnt (
        .clk_i   (mclk_i),
        .rst_b_i (rst_sync_b),
        .inc_i   (evt_i.hec_corrected_seen),
        .clr_i   (rd_at(`ACSC_OFS_CORR_COUNT)),
        .cnt_o   (corr_cnt)
    );

    // Upper bytes captured by the low byte read, cleared by their own read
    always_ff @(posedge mclk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            idle_mid_ff  <= `ACSC_RST_BYTE;
            idle_high_ff <= '0;
            sent_mid_ff  <= `ACSC_RST_BYTE;
            sent_high_ff <= '0;
        end else begin
            if (rd_at(`ACSC_OFS_IDLE_LOW)) begin
                idle_mid_ff  <= idle_cnt[15:8];
                idle_high_ff <= idle_cnt[CW-1:16];
            end
            if (rd_at(`ACSC_OFS_IDLE_MID)) begin
                idle_mid_ff <= `ACSC_RST_BYTE;
            end
            if (rd_at(`ACSC_OFS_IDLE_HIGH)) begin
                idle_high_ff <= '0;
            end
            if (rd_at(`ACSC_OFS_TX_LOW)) begin
                sent_mid_ff  <= sent_cnt[15:8];
                sent_high_ff <= sent_cnt[CW-1:16];
            end
            if (rd_at(`ACSC_OFS_TX_MID)) begin
                sent_mid_ff <= `ACSC_RST_BYTE;
            end
            if (rd_at(`ACSC_OFS_TX_HIGH)) begin
                sent_high_ff <= '0;
            end
        end
    end

    // Interrupt events: delineation on both edges, then the cell events
    assign int_ev = {loss_change, evt_i.hec_uncorrected_seen,
                     evt_i.hec_corrected_seen, evt_i.sent_cell,
                     evt_i.valid_cell_seen, evt_i.idle_cell_seen,
                     evt_i.screened_out_cell, evt_i.gfc_nonzero_seen};

    // Interrupt status (write one to clear, set wins) and mask
    always_ff @(posedge mclk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            int_st_ff   <= `ACSC_RST_BYTE;
            int_mask_ff <= `ACSC_RST_MASK;
        end else begin
            if (wr_at(`ACSC_OFS_INT_STATUS)) begin
                int_st_ff <= (int_st_ff & ~wdata_i) | int_ev;
            end else begin
                int_st_ff <= int_st_ff | int_ev;
            end
            if (wr_at(`ACSC_OFS_INT_MASK)) begin
                int_mask_ff <= wdata_i;
            end
        end
    end

    // Interrupt output from a flop
    always_ff @(posedge mclk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(int_st_ff & int_mask_ff);
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        case (addr_i)
            `ACSC_OFS_RX_STATUS: begin
                rd_mux = rx_ev_ff;
                rd_mux[`ACSC_BIT_LOSS] = evt_i.delineation_lost;
            end
            `ACSC_OFS_IDLE_LOW:   rd_mux = idle_cnt[7:0];
            `ACSC_OFS_IDLE_MID:   rd_mux = idle_mid_ff;
            `ACSC_OFS_IDLE_HIGH:  rd_mux = {{(8-HW){1'b0}}, idle_high_ff};
            `ACSC_OFS_LOSS_COUNT: rd_mux = loss_cnt;
            `ACSC_OFS_TX_LOW:     rd_mux = sent_cnt[7:0];
            `ACSC_OFS_TX_MID:     rd_mux = sent_mid_ff;
            `ACSC_OFS_TX_HIGH:    rd_mux = {{(8-HW){1'b0}}, sent_high_ff};
            `ACSC_OFS_CORR_COUNT: rd_mux = corr_cnt;
            `ACSC_OFS_INT_STATUS: rd_mux = int_st_ff;
            `ACSC_OFS_INT_MASK:   rd_mux = int_mask_ff;
            default:              rd_mux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the read strobe
    always_ff @(posedge mclk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rdata_o <= `ACSC_RST_BYTE;
        end else begin
            rdata_o <= rd_i ? rd_mux : 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_sync_b);

    chk_status_clear_read: assert property (
        rd_at(`ACSC_OFS_RX_STATUS) && evt_i[6:1] == 6'h00 |=> rx_ev_ff == 8'h00
    ) else $error("status event bits not cleared by read");

    chk_loss_bit_live: assert property (
        rd_at(`ACSC_OFS_RX_STATUS) |=> rdata_o[7] == $past(evt_i.delineation_lost)
    ) else $error("loss bit does not follow delineation state");

    chk_event_holds: assert property (
        rx_ev_ff[3] && !rd_at(`ACSC_OFS_RX_STATUS) |=> rx_ev_ff[3]
    ) else $error("sticky status bit dropped without a read");

    chk_uncorr_bit_set: assert property (
        evt_i.hec_uncorrected_seen |=> rx_ev_ff[6]
    ) else $error("uncorrected header bit not set");

    chk_corr_bit_set: assert property (
        evt_i.hec_corrected_seen |=> rx_ev_ff[5]
    ) else $error("corrected header bit not set");

    chk_valid_bit_set: assert property (
        evt_i.valid_cell_seen |=> rx_ev_ff[3]
    ) else $error("valid cell bit not set");

    chk_idle_bit_set: assert property (
        evt_i.idle_cell_seen |=> rx_ev_ff[2]
    ) else $error("idle cell bit not set");

    chk_screen_bit_set: assert property (
        evt_i.screened_out_cell |=> rx_ev_ff[1]
    ) else $error("screened cell bit not set");

    chk_gfc_bit_set: assert property (
        evt_i.gfc_nonzero_seen |=> rx_ev_ff[0]
    ) else $error("nonzero GFC bit not set");

    chk_high_byte_zero: assert property (
        rd_at(`ACSC_OFS_IDLE_HIGH) |=> rdata_o[7:3] == 5'h00
    ) else $error("idle high byte upper bits not zero");

    chk_idle_low_clear: assert property (
        rd_at(`ACSC_OFS_IDLE_LOW) |=> idle_cnt == CW'($past(evt_i.idle_cell_seen))
    ) else $error("idle counter not cleared by low byte read");

    chk_loss_count_rise: assert property (
        !evt_i.delineation_lost ##1 evt_i.delineation_lost && loss_cnt != 8'hFF
        |=> loss_cnt == $past(loss_cnt) + 8'h01
    ) else $error("loss counter missed a delineation loss");

    chk_loss_no_recover: assert property (
        evt_i.delineation_lost ##1 !evt_i.delineation_lost |=> $stable(loss_cnt)
    ) else $error("loss counter moved on recovery");

    chk_loss_irq_both: assert property (
        $changed(evt_i.delineation_lost) |=> int_st_ff[7]
    ) else $error("delineation interrupt event missed");

    chk_sent_snapshot: assert property (
        rd_at(`ACSC_OFS_TX_LOW) ##1 !rd_i [*2]
        |=> sent_mid_ff == $past(sent_cnt[15:8], 3)
    ) else $error("sent counter mid byte not captured");

    chk_corr_sat: assert property (
        corr_cnt == 8'hFF && !rd_at(`ACSC_OFS_CORR_COUNT) |=> corr_cnt == 8'hFF
    ) else $error("corrected counter wrapped");

    chk_corr_clear_ev: assert property (
        rd_at(`ACSC_OFS_CORR_COUNT) && evt_i.hec_corrected_seen |=> corr_cnt == 8'h01
    ) else $error("event lost during clearing read");

    chk_sent_low_clear: assert property (
        rd_at(`ACSC_OFS_TX_LOW) |=> sent_cnt == CW'($past(evt_i.sent_cell))
    ) else $error("sent counter not cleared by low byte read");

    chk_mid_read_clear: assert property (
        rd_at(`ACSC_OFS_IDLE_MID) |=> idle_mid_ff == 8'h00
    ) else $error("idle mid byte not cleared by its read");

    chk_corr_count_step: assert property (
        evt_i.hec_corrected_seen && !rd_at(`ACSC_OFS_CORR_COUNT) && corr_cnt != 8'hFF
        |=> corr_cnt == $past(corr_cnt) + 8'h01
    ) else $error("corrected counter missed an event");

    cov_status_read:  cover property (rd_at(`ACSC_OFS_RX_STATUS) ##1 rdata_o != 8'h00);
    cov_idle_sequence: cover property (rd_at(`ACSC_OFS_IDLE_LOW) ##2 rd_at(`ACSC_OFS_IDLE_MID)
                                       ##2 rd_at(`ACSC_OFS_IDLE_HIGH));
    cov_loss_cycle:   cover property (evt_i.delineation_lost ##[1:20] !evt_i.delineation_lost);
    cov_irq_raised:   cover property ($rose(irq_o));

endmodule : acsc_top

/* include/acsc_params.svh */
/*
 * Register offsets, bit positions and reset values of the ATM cell status
 * and counter bank. Assumes byte-wide registers on a plain strobe port.
 */
`ifndef ACSC_PARAMS_SVH
`define ACSC_PARAMS_SVH

// Register offsets
`define ACSC_OFS_RX_STATUS   8'h2F
`define ACSC_OFS_IDLE_LOW    8'h30
`define ACSC_OFS_IDLE_MID    8'h31
`define ACSC_OFS_IDLE_HIGH   8'h32
`define ACSC_OFS_LOSS_COUNT  8'h33
`define ACSC_OFS_TX_LOW      8'h34
`define ACSC_OFS_TX_MID      8'h35
`define ACSC_OFS_TX_HIGH     8'h36
`define ACSC_OFS_CORR_COUNT  8'h37
`define ACSC_OFS_INT_STATUS  8'h40
`define ACSC_OFS_INT_MASK    8'h41

// Receive status bit positions
`define ACSC_BIT_LOSS        7
`define ACSC_BIT_UNCORR      6
`define ACSC_BIT_CORR        5
`define ACSC_BIT_RSVD        4
`define ACSC_BIT_VALID       3
`define ACSC_BIT_IDLE        2
`define ACSC_BIT_SCREEN      1
`define ACSC_BIT_GFC         0

// Reset values
`define ACSC_RST_BYTE        8'h00
`define ACSC_RST_MASK        8'h00

`endif

/* include/acsc_pkg.sv */
/*
 * Types of the ATM cell status and counter bank.
 * Assumes all event inputs are synchronous to the bank clock.
 */
package acsc_pkg;

    // Event inputs from the cell receiver and transmitter
    typedef struct packed {
        logic delineation_lost;      // Level: delineation currently lost
        logic hec_uncorrected_seen;  // Pulse: uncorrectable header error
        logic hec_corrected_seen;    // Pulse: header error corrected
        logic valid_cell_seen;       // Pulse: valid cell received
        logic idle_cell_seen;        // Pulse: idle header match
        logic screened_out_cell;     // Pulse: cell rejected by screening
        logic gfc_nonzero_seen;      // Pulse: nonzero GFC in header
        logic sent_cell;             // Pulse: cell transmitted
    } acsc_evt_s;

    typedef logic [7:0] acsc_byte_t;

endpackage : acsc_pkg

/* src/acsc_counter.sv */
/*
 * Saturating event counter with a synchronous clear.
 * Assumes one clock; clear and increment in one cycle give a count of one.
 */
`timescale 1ns/1ps

module acsc_counter #(
    parameter int W = 8
) (
    input  wire logic         clk_i,   // Bank clock
    input  wire logic         rst_b_i, // Synchronised reset, active low
    input  wire logic         inc_i,   // One-cycle count pulse
    input  wire logic         clr_i,   // One-cycle clear pulse
    output logic [W-1:0]      cnt_o    // Present count
);

    localparam logic [W-1:0] ALL_ONES = {W{1'b1}};
    localparam logic [W-1:0] ONE      = {{(W-1){1'b0}}, 1'b1};

    // Clear, then count; stop at all ones
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_o <= '0;
        end else if (clr_i) begin
            cnt_o <= inc_i ? ONE : '0;
        end else if (inc_i && cnt_o != ALL_ONES) begin
            cnt_o <= cnt_o + ONE;
        end
    end

endmodule : acsc_counter

/* test/acsc_top_bench.sv */
/*
 * Self-checking bench of the ATM cell status and counter bank.
 * Assumes acsc_top, acsc_pkg and acsc_params.svh are compiled alongside.
 */
`timescale 1ns/1ps
`include "acsc_params.svh"

module acsc_top_bench;
    logic                mclk_i;      // Bank clock
    logic                rst_b_i;     // Reset, active low
    logic [7:0]          addr_i;      // Register address
    logic [7:0]          wdata_i;     // Write data
    logic                wr_i;        // Write strobe
    logic                rd_i;        // Read strobe
    acsc_pkg::acsc_evt_s evt;         // Event inputs
    logic [7:0]          rdata_o;     // Read data
    logic                irq_o;       // Interrupt
    int                  miscompares;
    int                  num_checks;
    logic [18:0]         exp_idle;    // Expected idle count
    logic [18:0]         exp_tx;      // Expected sent count
    logic [7:0]          exp_corr;    // Expected corrected count
    logic [7:0]          v;
    int                  n;

    acsc_top #(.CW(19)) u_dut (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .addr_i  (addr_i),
        .wdata_i (wdata_i),
        .wr_i    (wr_i),
        .rd_i    (rd_i),
        .evt_i   (evt),
        .rdata_o (rdata_o),
        .irq_o   (irq_o)
    );

    // Clock at 40 ns
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // Receive status bit of an event index; sent cells have none
    function automatic logic [7:0] st_exp(input int k);
        return (k == 0) ? 8'h00 : 8'h01 << ((k >= 5) ? k : k - 1);
    endfunction : st_exp

    // Interrupt status bit of an event index
    function automatic logic [7:0] int_exp(input int k);
        return 8'h01 << ((k == 0) ? 4 : ((k >= 5) ? k : k - 1));
    endfunction : int_exp

    // Saturating addition for the expected counts
    function automatic logic [18:0] sat_add(input logic [18:0] c, input int d, input int top);
        return ((int'(c) + d) > top) ? 19'(top) : 19'(int'(c) + d);
    endfunction : sat_add

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %02h seen %02h", name, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : chk1

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : reg_wr

    // Read; k >= 0 also pulses that event in the read cycle
    task automatic reg_rd(input logic [7:0] a, input int k, output logic [7:0] d);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        if (k >= 0) evt[k] <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        if (k >= 0) evt[k] <= 1'b0;
        @(negedge mclk_i);
        d = rdata_o;
    endtask : reg_rd

    // Hold an event high for cnt edges and track expected counts
    task automatic pulse(input int k, input int cnt);
        @(posedge mclk_i);
        evt[k] <= 1'b1;
        repeat (cnt) @(posedge mclk_i);
        evt[k] <= 1'b0;
        if (k == 3) exp_idle = sat_add(exp_idle, cnt, 19'h7FFFF);
        if (k == 0) exp_tx = sat_add(exp_tx, cnt, 19'h7FFFF);
        if (k == 5) exp_corr = 8'(sat_add(19'(exp_corr), cnt, 255));
    endtask : pulse

    // Read a three-byte counter, optionally with an event beside the low read
    task automatic rd_cnt19(input logic [7:0] base, input int k, input bit same, input int extra);
        logic [18:0] snap;
        snap = (k == 3) ? exp_idle : exp_tx;
        reg_rd(base, same ? k : -1, v);
        chk8("count low", snap[7:0], v);
        if (k == 3) exp_idle = 19'(same);
        else exp_tx = 19'(same);
        if (extra > 0) pulse(k, extra);
        reg_rd(base + 8'h01, -1, v);
        chk8("count mid", snap[15:8], v);
        reg_rd(base + 8'h02, -1, v);
        chk8("count high", {5'h00, snap[18:16]}, v);
        reg_rd(base + 8'h01, -1, v);
        chk8("count mid cleared", 8'h00, v);
    endtask : rd_cnt19

    task automatic test_done();
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge mclk_i);
        miscompares++;
        test_done();
    end

    // Main sequence
    initial begin
        void'($urandom(82240));
        rst_b_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        evt = '0;
        miscompares = 0;
        num_checks = 0;
        exp_idle = '0;
        exp_tx = '0;
        exp_corr = 8'h00;
        repeat (16) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        for (int a = 8'h2F; a <= 8'h41; a++) begin
            reg_rd(8'(a), -1, v);
            chk8("reset value", 8'h00, v);
        end
        reg_wr(`ACSC_OFS_LOSS_COUNT, 8'hFF);
        reg_wr(`ACSC_OFS_RX_STATUS, 8'hFF);
        reg_rd(`ACSC_OFS_LOSS_COUNT, -1, v);
        chk8("loss count ro", 8'h00, v);
        // Every pulse event: status bit, clear on read, interrupt mask and clear
        for (int k = 0; k < 7; k++) begin
            pulse(k, $urandom_range(1, 4));
            repeat (2) @(posedge mclk_i);
            @(negedge mclk_i) chk1("irq masked", 1'b0, irq_o);
            reg_rd(`ACSC_OFS_RX_STATUS, -1, v);
            chk8("rx status", st_exp(k), v & 8'hEF);
            reg_rd(`ACSC_OFS_RX_STATUS, -1, v);
            chk8("rx status cleared", 8'h00, v);
            reg_rd(`ACSC_OFS_INT_STATUS, -1, v);
            chk8("int status", int_exp(k), v);
            reg_wr(`ACSC_OFS_INT_MASK, int_exp(k));
            repeat (2) @(posedge mclk_i);
            @(negedge mclk_i) chk1("irq set", 1'b1, irq_o);
            reg_wr(`ACSC_OFS_INT_STATUS, int_exp(k));
            repeat (2) @(posedge mclk_i);
            @(negedge mclk_i) chk1("irq cleared", 1'b0, irq_o);
            reg_wr(`ACSC_OFS_INT_MASK, 8'h00);
        end
        // Event in the clearing read cycle stays latched
        reg_rd(`ACSC_OFS_RX_STATUS, 4, v);
        reg_rd(`ACSC_OFS_RX_STATUS, -1, v);
        chk8("status set wins", 8'h08, v);
        reg_wr(`ACSC_OFS_INT_STATUS, 8'hFF);
        // Delineation loss: live bit, dual-edge interrupt, loss count
        @(posedge mclk_i) evt.delineation_lost <= 1'b1;
        repeat (2) begin
            reg_rd(`ACSC_OFS_RX_STATUS, -1, v);
            chk8("live loss", 8'h80, v);
        end
        reg_rd(`ACSC_OFS_INT_STATUS, -1, v);
        chk8("loss int rise", 8'h80, v);
        reg_wr(`ACSC_OFS_INT_STATUS, 8'h80);
        @(posedge mclk_i) evt.delineation_lost <= 1'b0;
        reg_rd(`ACSC_OFS_INT_STATUS, -1, v);
        chk8("loss int fall", 8'h80, v);
        reg_rd(`ACSC_OFS_RX_STATUS, -1, v);
        chk8("live regained", 8'h00, v);
        reg_rd(`ACSC_OFS_LOSS_COUNT, -1, v);
        chk8("loss count", 8'h01, v);
        n = $urandom_range(2, 9);
        repeat (n) begin
            @(posedge mclk_i) evt.delineation_lost <= 1'b1;
            repeat ($urandom_range(1, 3)) @(posedge mclk_i);
            evt.delineation_lost <= 1'b0;
            repeat ($urandom_range(1, 3)) @(posedge mclk_i);
        end
        repeat (2) begin
            reg_rd(`ACSC_OFS_LOSS_COUNT, -1, v);
            chk8("loss count kept", 8'(n + 1), v);
        end
        repeat (260) begin
            @(posedge mclk_i) evt.delineation_lost <= 1'b1;
            @(posedge mclk_i) evt.delineation_lost <= 1'b0;
        end
        reg_rd(`ACSC_OFS_LOSS_COUNT, -1, v);
        chk8("loss count sat", 8'hFF, v);
        // Three-byte counters: plain, snapshot, same-cycle event
        rd_cnt19(`ACSC_OFS_IDLE_LOW, 3, 1'b0, 0);
        rd_cnt19(`ACSC_OFS_TX_LOW, 0, 1'b0, 0);
        pulse(3, $urandom_range(300, 1500));
        pulse(0, $urandom_range(300, 1500));
        rd_cnt19(`ACSC_OFS_IDLE_LOW, 3, 1'b0, $urandom_range(1, 300));
        rd_cnt19(`ACSC_OFS_TX_LOW, 0, 1'b1, $urandom_range(1, 300));
        rd_cnt19(`ACSC_OFS_IDLE_LOW, 3, 1'b1, 0);
        rd_cnt19(`ACSC_OFS_TX_LOW, 0, 1'b0, 0);
        // Corrected header error counter: clear, saturate, same-cycle event
        reg_rd(`ACSC_OFS_CORR_COUNT, -1, v);
        chk8("corr count", exp_corr, v);
        exp_corr = 8'h00;
        pulse(5, 300);
        reg_rd(`ACSC_OFS_CORR_COUNT, 5, v);
        chk8("corr count sat", 8'hFF, v);
        reg_rd(`ACSC_OFS_CORR_COUNT, -1, v);
        chk8("corr count one", 8'h01, v);
        reg_rd(`ACSC_OFS_CORR_COUNT, -1, v);
        chk8("corr count clear", 8'h00, v);
        test_done();
    end
endmodule : acsc_top_bench
